// *** rtl/servo_status_outputs.sv ***
// Servo drive status and feedback outputs with an AXI4-Lite register file
//
// How it works
// - Rotation detect is on while speed magnitude exceeds the rotation level register.
// - Alarm output is on normally and turns off when any fault is seen.
// - Ready is on only with power good and no alarm latched.
// - Encoder phases A and B are re-timed onto the quadrature outputs.
// - Encoder reference mark is re-timed onto the zero mark output.
// - Speed mode: speed agree on while speed is within band of reference.
// - Position mode: position done on while error magnitude is within width.
// - Three output slots carry a function chosen by the map register.
// - Torque limited flag is on while torque magnitude reaches the limit.
// - Brake release output follows the software brake request bit.
// - C pulse, overtravel, excitation and home flags are selectable functions.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "servo_status_consts.svh"
module servo_status_outputs (
  input  wire logic        aclk,                // 250 MHz clock
  input  wire logic        aresetn,             // Synchronous reset, active low
  input  wire logic [7:0]  s_axi_awaddr,        // Write address
  input  wire logic        s_axi_awvalid,       // Write address valid
  output logic             s_axi_awready,       // Write address ready
  input  wire logic [31:0] s_axi_wdata,         // Write data
  input  wire logic [3:0]  s_axi_wstrb,         // Write byte strobes
  input  wire logic        s_axi_wvalid,        // Write data valid
  output logic             s_axi_wready,        // Write data ready
  output logic [1:0]       s_axi_bresp,         // Write response
  output logic             s_axi_bvalid,        // Write response valid
  input  wire logic        s_axi_bready,        // Write response ready
  input  wire logic [7:0]  s_axi_araddr,        // Read address
  input  wire logic        s_axi_arvalid,       // Read address valid
  output logic             s_axi_arready,       // Read address ready
  output logic [31:0]      s_axi_rdata,         // Read data
  output logic [1:0]       s_axi_rresp,         // Read response
  output logic             s_axi_rvalid,        // Read data valid
  input  wire logic        s_axi_rready,        // Read data ready
  input  wire logic signed [15:0] motor_speed_in, // Measured speed
  input  wire logic signed [15:0] ref_speed_in, // Speed reference
  input  wire logic signed [15:0] pos_error_in, // Accumulated position error
  input  wire logic signed [15:0] torque_in,    // Measured torque
  input  wire logic        enc_a_in,            // Encoder phase A
  input  wire logic        enc_b_in,            // Encoder phase B
  input  wire logic        enc_z_in,            // Encoder reference mark
  input  wire logic [7:0]  fault_in,            // Error conditions, any set is an alarm
  input  wire logic        power_good_in,       // Control and main power up
  input  wire logic        alarm_clear_in,      // Alarm reset from the host
  input  wire logic        overtravel_in,       // Overtravel limit reached
  input  wire logic        excite_in,           // Motor excitation enabled
  input  wire logic        home_done_in,        // Homing completed
  output logic             rotation_detect_out, // Motor rotating
  output logic             alarm_out,           // On while healthy
  output logic             ready_out,           // Servo ready
  output logic             speed_agree_out,     // Speed agreement
  output logic             position_done_out,   // Positioning done
  output logic             torque_limited_out,  // Torque at limit
  output logic             brake_release_out,   // Brake released when high
  output logic             c_pulse_out,         // C pulse
  output logic             overtravel_out,      // Overtravel indication
  output logic             excite_out,          // Excitation indication
  output logic             home_done_out,       // Home completion
  output logic             quad_phase_a_out,    // Phase A pulse
  output logic             quad_phase_b_out,    // Phase B pulse
  output logic             zero_mark_out,       // Phase C zero mark
  output logic [2:0]       slot_out,            // Remappable pins: run, ready, speed agreement in speed mode or position_done_out in position mode
  output logic             irq                  // Level interrupt
);
  import servo_status_pkg::*;

  state_t s_r;
  state_t s_nxt;
  logic   wr_fire;
  logic   fault_any;
  logic   clear_edge;
  logic [15:0] speed_mag;
  logic [15:0] err_mag;
  logic [15:0] torq_mag;
  logic [15:0] diff_mag;
  logic [16:0] diff_full;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic        wr_ok;
  logic [8:0]  fn_vec;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Magnitude of a signed value, saturating the most negative code
  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    logic [15:0] m;
    m = v[15] ? 16'(-v) : 16'(v);
    if (m[15])
      m = 16'h7FFF;
    return m;
  endfunction

  // Comparator operands and events
  always_comb
  begin
    speed_mag  = mag16(motor_speed_in);
    err_mag    = mag16(pos_error_in);
    torq_mag   = mag16(torque_in);
    diff_full  = 17'({motor_speed_in[15], motor_speed_in})
               - 17'({ref_speed_in[15], ref_speed_in});
    diff_mag   = diff_full[16] ? 16'(-diff_full) : diff_full[15:0];
    fault_any  = |fault_in;
    clear_edge = alarm_clear_in && !s_r.clear_prev;
    wr_fire    = s_r.aw_have && s_r.w_have && !s_r.bvalid;
  end

  // Read decode
  always_comb
  begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      `OFF_CTRL:       rd_word = {30'h0, s_r.brake_req, s_r.mode};
      `OFF_ROT_LEVEL:  rd_word = {16'h0, s_r.rot_level};
      `OFF_AGREE_BAND: rd_word = {16'h0, s_r.agree_band};
      `OFF_DONE_WIDTH: rd_word = {16'h0, s_r.done_width};
      `OFF_TORQ_LIMIT: rd_word = {16'h0, s_r.torq_limit};
      `OFF_OUT_MAP:    rd_word = {20'h0, s_r.out_map};
      `OFF_STATUS:     rd_word = {20'h0, s_r.home, s_r.excite, s_r.overtrav, s_r.brake_rel,
                                  s_r.torq_lim, s_r.pos_done, s_r.speed_agree, s_r.ready,
                                  s_r.alarm, s_r.rot_det, s_r.quad_b, s_r.quad_a};
      `OFF_IRQ_STAT:   rd_word = {29'h0, s_r.irq_stat};
      `OFF_IRQ_MASK:   rd_word = {29'h0, s_r.irq_mask};
      default:         rd_ok   = 1'b0;
    endcase
  end

  // Write address check
  always_comb
  begin
    unique case (s_r.aw_addr)
      `OFF_CTRL, `OFF_ROT_LEVEL, `OFF_AGREE_BAND, `OFF_DONE_WIDTH, `OFF_TORQ_LIMIT,
      `OFF_OUT_MAP, `OFF_STATUS, `OFF_IRQ_STAT, `OFF_IRQ_MASK: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Function vector indexed by out_func_t
  always_comb
  begin
    fn_vec = {s_r.home, s_r.excite, s_r.overtrav, s_r.c_pulse, s_r.brake_rel, s_r.torq_lim,
              (s_r.mode == MODE_POSITION) ? s_r.pos_done : s_r.speed_agree,
              s_r.ready, s_r.rot_det};
  end

  // Next state
  always_comb
  begin
    s_nxt = s_r;
    // Write channel capture, either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready)
      s_nxt.bvalid = 1'b0;
    // Register write; status is read only, unmapped gets SLVERR
    if (wr_fire)
    begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = wr_ok ? `AXI_OKAY : `AXI_SLVERR;
      if (s_r.w_strb[0])
      begin
        unique case (s_r.aw_addr)
          `OFF_CTRL:
          begin
            s_nxt.mode      = ctrl_mode_t'(s_r.w_data[`CTRL_MODE_BIT]);
            s_nxt.brake_req = s_r.w_data[`CTRL_BRAKE_BIT];
          end
          `OFF_ROT_LEVEL:  s_nxt.rot_level[7:0]  = s_r.w_data[7:0];
          `OFF_AGREE_BAND: s_nxt.agree_band[7:0] = s_r.w_data[7:0];
          `OFF_DONE_WIDTH: s_nxt.done_width[7:0] = s_r.w_data[7:0];
          `OFF_TORQ_LIMIT: s_nxt.torq_limit[7:0] = s_r.w_data[7:0];
          `OFF_OUT_MAP:    s_nxt.out_map[7:0]    = s_r.w_data[7:0];
          `OFF_IRQ_STAT:   s_nxt.irq_stat = s_r.irq_stat & ~s_r.w_data[2:0];
          `OFF_IRQ_MASK:   s_nxt.irq_mask = s_r.w_data[2:0];
          default: ;
        endcase
      end
      if (s_r.w_strb[1])
      begin
        unique case (s_r.aw_addr)
          `OFF_ROT_LEVEL:  s_nxt.rot_level[15:8]  = s_r.w_data[15:8];
          `OFF_AGREE_BAND: s_nxt.agree_band[15:8] = s_r.w_data[15:8];
          `OFF_DONE_WIDTH: s_nxt.done_width[15:8] = s_r.w_data[15:8];
          `OFF_TORQ_LIMIT: s_nxt.torq_limit[15:8] = s_r.w_data[15:8];
          `OFF_OUT_MAP:    s_nxt.out_map[11:8]    = s_r.w_data[11:8];
          default: ;
        endcase
      end
    end
    // Read channel
    if (s_r.rvalid && s_axi_rready)
      s_nxt.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rd_word;
      s_nxt.rresp  = rd_ok ? `AXI_OKAY : `AXI_SLVERR;
    end
    // Alarm latch: a present fault blocks the clear
    s_nxt.clear_prev = alarm_clear_in;
    if (fault_any)
      s_nxt.alarm = 1'b1;
    else if (clear_edge)
      s_nxt.alarm = 1'b0;
    // Status flags
    s_nxt.rot_det     = speed_mag > s_r.rot_level;
    s_nxt.ready       = power_good_in && !s_r.alarm && !fault_any;
    s_nxt.speed_agree = (s_r.mode == MODE_SPEED) && (diff_mag <= s_r.agree_band);
    s_nxt.pos_done    = (s_r.mode == MODE_POSITION) && (err_mag <= s_r.done_width);
    s_nxt.torq_lim    = torq_mag >= s_r.torq_limit;
    s_nxt.brake_rel   = s_r.brake_req;
    s_nxt.quad_a      = enc_a_in;
    s_nxt.quad_b      = enc_b_in;
    s_nxt.zero_mark   = enc_z_in;
    s_nxt.c_pulse     = enc_z_in;
    s_nxt.overtrav    = overtravel_in;
    s_nxt.excite      = excite_in && !s_r.alarm;
    s_nxt.home        = home_done_in;
    // Remappable pins, unused codes read low
    for (int i = 0; i < 3; i++)
    begin
      if (s_r.out_map[4*i +: 4] <= 4'(FN_HOME))
        s_nxt.slot[i] = fn_vec[s_r.out_map[4*i +: 4]];
      else
        s_nxt.slot[i] = 1'b0;
    end
    // Sticky interrupt events; set wins over a clear in the same cycle
    if (fault_any && !s_r.alarm)
      s_nxt.irq_stat[`IRQ_ALARM_BIT] = 1'b1;
    if (enc_z_in && !s_r.zero_mark)
      s_nxt.irq_stat[`IRQ_ZERO_BIT] = 1'b1;
    if (s_nxt.ready && !s_r.ready)
      s_nxt.irq_stat[`IRQ_READY_BIT] = 1'b1;
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r            <= '0;
      s_r.mode       <= MODE_SPEED;
      s_r.rot_level  <= `RST_ROT_LEVEL;
      s_r.agree_band <= `RST_AGREE_BAND;
      s_r.done_width <= `RST_DONE_WIDTH;
      s_r.torq_limit <= `RST_TORQ_LIMIT;
      s_r.out_map    <= `RST_OUT_MAP;
    end
    else
      s_r <= s_nxt;
  end

  // Bus handshakes and outputs
  assign s_axi_awready       = !s_r.aw_have && !s_r.bvalid;
  assign s_axi_wready        = !s_r.w_have && !s_r.bvalid;
  assign s_axi_bvalid        = s_r.bvalid;
  assign s_axi_bresp         = s_r.bresp;
  assign s_axi_arready       = !s_r.rvalid;
  assign s_axi_rvalid        = s_r.rvalid;
  assign s_axi_rdata         = s_r.rdata;
  assign s_axi_rresp         = s_r.rresp;
  assign rotation_detect_out = s_r.rot_det;
  assign alarm_out           = !s_r.alarm;
  assign ready_out           = s_r.ready;
  assign speed_agree_out     = s_r.speed_agree;
  assign position_done_out   = s_r.pos_done;
  assign torque_limited_out  = s_r.torq_lim;
  assign brake_release_out   = s_r.brake_rel;
  assign c_pulse_out         = s_r.c_pulse;
  assign overtravel_out      = s_r.overtrav;
  assign excite_out          = s_r.excite;
  assign home_done_out       = s_r.home;
  assign quad_phase_a_out    = s_r.quad_a;
  assign quad_phase_b_out    = s_r.quad_b;
  assign zero_mark_out       = s_r.zero_mark;
  assign slot_out            = s_r.slot;
  assign irq                 = |(s_r.irq_stat & s_r.irq_mask);

  // Checks
  sequence clear_req;
    alarm_clear_in && !s_r.clear_prev && !fault_any;
  endsequence
  sequence fault_seen;
    fault_any;
  endsequence

  chk_rot_detect: assert property (##1 rotation_detect_out
                                   == $past(speed_mag > s_r.rot_level))
    else $error("rotation detect does not follow speed");
  // A clear that lands once the fault has gone may release the alarm in the second cycle
  chk_alarm_off: assert property (fault_seen |=> !alarm_out
                                  ##1 (!alarm_out || $past(clear_edge && !fault_any)))
    else $error("alarm output stayed on after a fault");
  chk_alarm_clear: assert property (!alarm_out ##0 clear_req |=> alarm_out)
    else $error("alarm not released by clear");
  chk_ready_gate: assert property (ready_out |-> alarm_out && $past(power_good_in))
    else $error("ready on with alarm or no power");
  chk_quad_follow: assert property (##1 quad_phase_a_out == $past(enc_a_in)
                                    && quad_phase_b_out == $past(enc_b_in))
    else $error("quadrature outputs lag wrong");
  chk_zero_mark: assert property ($rose(enc_z_in) |=> $rose(zero_mark_out))
    else $error("zero mark missed");
  chk_speed_agree: assert property (speed_agree_out |-> $past(s_r.mode) == MODE_SPEED
                                    && $past(diff_mag) <= $past(s_r.agree_band))
    else $error("speed agree set outside band");
  chk_pos_done: assert property (s_r.mode == MODE_POSITION && err_mag <= s_r.done_width
                                 && $stable(s_r.mode) |=> position_done_out)
    else $error("position done missing");
  chk_map_slot: assert property (s_r.out_map[3:0] == 4'(FN_TORQUE)
                                 && $stable(s_r.out_map) |=> slot_out[0] == $past(s_r.torq_lim))
    else $error("slot does not carry mapped function");
  chk_torque_flag: assert property (torq_mag >= s_r.torq_limit |=> torque_limited_out)
    else $error("torque limit flag missing");
  chk_brake_follow: assert property ($rose(s_r.brake_req) |=> brake_release_out)
    else $error("brake not released on request");
  chk_position_done_out_share: assert property (s_r.out_map[11:8] == 4'(FN_POSITION_DONE_OUT)
                                   && $stable(s_r.out_map)
                                   && s_r.mode == MODE_POSITION && $stable(s_r.mode)
                                   |=> slot_out[2] == $past(position_done_out))
    else $error("position_done_out slot not carrying position done");
  // Interrupt events: a set lands even when a clear falls in the same cycle
  chk_alarm_event: assert property (fault_seen ##0 alarm_out
                                    |=> s_r.irq_stat[`IRQ_ALARM_BIT])
    else $error("alarm event not latched");
  chk_ready_event: assert property ($rose(ready_out) |-> s_r.irq_stat[`IRQ_READY_BIT])
    else $error("ready event not latched");
endmodule

// *** common/servo_status_consts.svh ***
// Register offsets, field positions and reset values for the servo status block
`ifndef SERVO_STATUS_CONSTS_SVH
`define SERVO_STATUS_CONSTS_SVH
`define OFF_CTRL        8'h00
`define OFF_ROT_LEVEL   8'h04
`define OFF_AGREE_BAND  8'h08
`define OFF_DONE_WIDTH  8'h0C
`define OFF_TORQ_LIMIT  8'h10
`define OFF_OUT_MAP     8'h14
`define OFF_STATUS      8'h18
`define OFF_IRQ_STAT    8'h1C
`define OFF_IRQ_MASK    8'h20
`define CTRL_MODE_BIT   0
`define CTRL_BRAKE_BIT  1
`define IRQ_ALARM_BIT   0
`define IRQ_ZERO_BIT    1
`define IRQ_READY_BIT   2
`define RST_ROT_LEVEL   16'h0014
`define RST_AGREE_BAND  16'h000A
`define RST_DONE_WIDTH  16'h0007
`define RST_TORQ_LIMIT  16'h0064
`define RST_OUT_MAP     12'h210
`define AXI_OKAY        2'h0
`define AXI_SLVERR      2'h2
`endif

// *** common/servo_status_pkg.sv ***
// Types shared by the servo status block and its users
package servo_status_pkg;
  // Functions that a remappable output slot can carry
  typedef enum logic [3:0] {
    FN_ROTATION = 4'h0,
    FN_READY    = 4'h1,
    FN_POSITION_DONE_OUT     = 4'h2,
    FN_TORQUE   = 4'h3,
    FN_BRAKE    = 4'h4,
    FN_CPULSE   = 4'h5,
    FN_OVERTRAV = 4'h6,
    FN_EXCITE   = 4'h7,
    FN_HOME     = 4'h8
  } out_func_t;

  // Active control mode
  typedef enum logic {
    MODE_SPEED    = 1'b0,
    MODE_POSITION = 1'b1
  } ctrl_mode_t;

  // All state of the block
  typedef struct packed {
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    ctrl_mode_t  mode;
    logic        brake_req;
    logic [15:0] rot_level;
    logic [15:0] agree_band;
    logic [15:0] done_width;
    logic [15:0] torq_limit;
    logic [11:0] out_map;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic        alarm;
    logic        clear_prev;
    logic        rot_det;
    logic        ready;
    logic        speed_agree;
    logic        pos_done;
    logic        torq_lim;
    logic        brake_rel;
    logic        quad_a;
    logic        quad_b;
    logic        zero_mark;
    logic        c_pulse;
    logic        overtrav;
    logic        excite;
    logic        home;
    logic [2:0]  slot;
  } state_t;
endpackage

// *** testbench/host_ctrl_model.sv ***
// Host controller model that samples the feedback pulses and issues alarm clears
`timescale 1ns/1ps
module host_ctrl_model (
  input  wire logic aclk,             // Bench clock
  input  wire logic aresetn,          // Reset, active low
  input  wire logic clear_req,        // Bench asks for one alarm clear
  input  wire logic quad_phase_a_out, // Phase A from the drive
  input  wire logic quad_phase_b_out, // Phase B from the drive
  input  wire logic zero_mark_out,    // Zero mark from the drive
  output logic      alarm_clear_in,   // Alarm clear pulse to the drive
  output int        a_edges,          // Phase A transitions seen
  output int        z_marks,          // Zero mark pulses seen
  output int        quad_errs         // Both phases moved at one edge
);
  logic pa;
  logic pb;
  logic pz;
  // One clock of alarm clear for each request
  always @(posedge aclk)
    alarm_clear_in <= clear_req && aresetn;
  // Count pulse activity as the host line receiver sees it
  always @(posedge aclk)
  begin
    pa <= quad_phase_a_out;
    pb <= quad_phase_b_out;
    pz <= zero_mark_out;
    if (!aresetn)
    begin
      a_edges   <= 0;
      z_marks   <= 0;
      quad_errs <= 0;
    end
    else
    begin
      if (pa != quad_phase_a_out)
        a_edges <= a_edges + 1;
      if (pa != quad_phase_a_out && pb != quad_phase_b_out)
        quad_errs <= quad_errs + 1;
      if (zero_mark_out && !pz)
        z_marks <= z_marks + 1;
    end
  end
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the servo status outputs block
`timescale 1ns/1ps
`include "servo_status_consts.svh"
module testbench;
  import servo_status_pkg::*;
  logic               aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]         awaddr = 8'h00, araddr = 8'h00;
  logic               awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic               bready = 1'b1, rready = 1'b1;
  logic [31:0]        wdata = 32'h0, rdata, d;
  logic [3:0]         wstrb = 4'hF;
  logic               awready, wready, bvalid, arready, rvalid;
  logic [1:0]         bresp, rresp, r;
  logic signed [15:0] spd = 16'h0, rsp = 16'h0, perr = 16'h0, trq = 16'h0;
  logic               ea = 1'b0, eb = 1'b0, ez = 1'b0, creq = 1'b0, clr;
  logic [7:0]         fault = 8'h00;
  logic               pg = 1'b0, otv = 1'b0, ex = 1'b0, hm = 1'b0;
  logic               rot, alr, rdy, sag, pdn, tql, brk, cp, oto, exo, hmo;
  logic               qa, qb, zm, irq;
  logic [2:0]         slot;
  int                 failures = 0, compares = 0, a_edges, z_marks, quad_errs;
  int                 m_mode = 0, m_brake = 0, m_alarm = 0, m_map = 32'h210;
  int                 th[4] = '{32'h14, 32'h0A, 32'h07, 32'h64};

  // 250 MHz clock
  always #2 aclk = ~aclk;

  servo_status_outputs servo_status_outputs_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .motor_speed_in(spd), .ref_speed_in(rsp), .pos_error_in(perr), .torque_in(trq),
    .enc_a_in(ea), .enc_b_in(eb), .enc_z_in(ez), .fault_in(fault), .power_good_in(pg),
    .alarm_clear_in(clr), .overtravel_in(otv), .excite_in(ex), .home_done_in(hm),
    .rotation_detect_out(rot), .alarm_out(alr), .ready_out(rdy), .speed_agree_out(sag),
    .position_done_out(pdn), .torque_limited_out(tql), .brake_release_out(brk),
    .c_pulse_out(cp), .overtravel_out(oto), .excite_out(exo), .home_done_out(hmo),
    .quad_phase_a_out(qa), .quad_phase_b_out(qb), .zero_mark_out(zm), .slot_out(slot),
    .irq(irq));

  host_ctrl_model host_ctrl_model_inst (.aclk(aclk), .aresetn(aresetn), .clear_req(creq),
    .quad_phase_a_out(qa), .quad_phase_b_out(qb), .zero_mark_out(zm),
    .alarm_clear_in(clr), .a_edges(a_edges), .z_marks(z_marks), .quad_errs(quad_errs));

  // Verdict and end of run
  task automatic conclude();
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic timeout();
    failures++;
    conclude();
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  // Register write: both channels offered together, released as taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] e);
    int n;
    logic ah;
    logic wh;
    logic bh;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid;
      e  = bresp;
      @(posedge aclk);
      if (ah)
        awvalid <= 1'b0;
      if (wh)
        wvalid <= 1'b0;
      if (bh)
        break;
    end
    if (n == 40)
      timeout();
  endtask

  // Register read
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
    int n;
    logic ah;
    logic rh;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      ah = arvalid & arready;
      rh = rvalid;
      v  = rdata;
      e  = rresp;
      @(posedge aclk);
      if (ah)
        arvalid <= 1'b0;
      if (rh)
        break;
    end
    if (n == 40)
      timeout();
  endtask

  function automatic int absv(input int v);
    return v < 0 ? -v : v;
  endfunction

  // Reference model of each selectable function
  function automatic logic fn(input int c);
    case (c)
      0: return absv(spd) > th[0];
      1: return pg && !m_alarm && fault == 8'h00;
      2: return m_mode ? absv(perr) <= th[2] : absv(spd - rsp) <= th[1];
      3: return absv(trq) >= th[3];
      4: return m_brake != 0;
      5: return ez;
      6: return otv;
      7: return ex && !m_alarm;
      8: return hm;
      default: return 1'b0;
    endcase
  endfunction

  task automatic check_all();
    chk("rotation", rot, fn(0));
    chk("alarm", alr, !m_alarm);
    chk("ready", rdy, fn(1));
    chk("speed agree", sag, !m_mode && fn(2));
    chk("position done", pdn, m_mode && fn(2));
    chk("torque", tql, fn(3));
    chk("brake", brk, fn(4));
    chk("c pulse", cp, fn(5));
    chk("overtravel", oto, fn(6));
    chk("excite", exo, fn(7));
    chk("home", hmo, fn(8));
    for (int i = 0; i < 3; i++)
      chk("slot", slot[i], fn((m_map >> (4 * i)) & 15));
  endtask

  task automatic pulse_clear();
    @(posedge aclk);
    creq <= 1'b1;
    @(posedge aclk);
    creq <= 1'b0;
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(32'h01FD));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 6; i++)
    begin
      axi_rd(8'(4 * i), d, r);
      chk("reset value", d, i == 0 ? 32'h0 : (i == 5 ? 32'h210 : 32'(th[i - 1])));
    end
    axi_rd(8'h40, d, r);
    chk("unmapped rresp", r, `AXI_SLVERR);
    chk("unmapped rdata", d, 32'h0);
    axi_wr(8'h40, 32'hFFFF, r);
    chk("unmapped bresp", r, `AXI_SLVERR);
    // Forward quadrature, one quarter step every two clocks
    for (int s = 1; s <= 16; s++)
    begin
      @(posedge aclk);
      ea <= (s % 4 == 1) || (s % 4 == 2);
      eb <= (s % 4 >= 2);
      ez <= (s % 8 == 7);
      step(1);
      chk("phase a", qa, ea);
      chk("phase b", qb, eb);
      chk("zero mark", zm, ez);
    end
    chk("a edges", a_edges, 8);
    chk("z marks", z_marks, 2);
    chk("quad errs", quad_errs, 0);
    // Random operating points around every threshold and map choice
    for (int it = 0; it < 40; it++)
    begin
      m_mode  = $urandom_range(0, 1);
      m_brake = $urandom_range(0, 1);
      m_map   = $urandom_range(0, 4095);
      axi_wr(`OFF_CTRL, 32'(2 * m_brake + m_mode), r);
      axi_wr(`OFF_OUT_MAP, 32'(m_map), r);
      for (int k = 0; k < 4; k++)
      begin
        th[k] = $urandom_range(0, 40);
        axi_wr(8'(4 + 4 * k), 32'(th[k]), r);
        chk("bresp", r, `AXI_OKAY);
      end
      spd  <= 16'(int'($urandom_range(0, 80)) - 40);
      rsp  <= 16'(int'($urandom_range(0, 80)) - 40);
      perr <= 16'(int'($urandom_range(0, 40)) - 20);
      trq  <= 16'(int'($urandom_range(0, 100)) - 50);
      {ez, pg, otv, ex, hm} <= 5'($urandom);
      step(3);
      check_all();
    end
    // Fault latches the alarm; a clear only works once the fault is gone
    @(posedge aclk);
    pg <= 1'b1;
    axi_wr(`OFF_IRQ_MASK, 32'h1, r);
    axi_wr(`OFF_IRQ_STAT, 32'h7, r);
    step(1);
    chk("irq idle", irq, 1'b0);
    @(posedge aclk);
    fault   <= 8'h10;
    m_alarm = 1;
    step(3);
    check_all();
    chk("irq alarm", irq, 1'b1);
    axi_wr(`OFF_IRQ_MASK, 32'h0, r);
    step(1);
    chk("irq masked", irq, 1'b0);
    pulse_clear();
    step(3);
    check_all();
    @(posedge aclk);
    fault <= 8'h00;
    step(3);
    check_all();
    pulse_clear();
    m_alarm = 0;
    step(3);
    check_all();
    axi_rd(`OFF_IRQ_STAT, d, r);
    chk("irq status", d[0], 1'b1);
    chk("irq ready", d[`IRQ_READY_BIT], 1'b1);
    axi_wr(`OFF_IRQ_MASK, 32'h1, r);
    step(1);
    chk("irq unmasked", irq, 1'b1);
    axi_wr(`OFF_IRQ_STAT, 32'h1, r);
    step(1);
    chk("irq cleared", irq, 1'b0);
    conclude();
  end
endmodule
